// ---- core/hie_top.sv ----
// Interrupt enable and mask register pair with interrupt request gating
`timescale 1ns/10ps
module hie_top
   import hie_pkg::*;
(
   input  wire logic        ref_clk_in,      // Controller clock, 25 MHz
   input  wire logic        rst_in,          // Hardware reset, sync high
   input  wire logic        sw_rst_in,       // Software reset pulse
   input  wire logic        cmd_valid_in,    // Command strobe
   input  wire logic [7:0]  cmd_code_in,     // Command code
   input  wire logic [31:0] cmd_wdata_in,    // Write data
   input  wire logic [6:0]  evt_in,          // Event pulses
   output logic      [31:0] rdata_out,       // Read data
   output logic             rdata_valid_out, // Read answer strobe
   output logic             irq_out          // Interrupt request, high
);

   hie_state_t  st_r;
   hie_state_t  st_nxt;
   hie_cmd_t    cmd;
   logic [6:0]  flags;
   logic [6:0]  flag_clr;
   logic        wr_en;
   logic        wr_dis;
   logic        wr_flag;
   logic        rd_en;
   logic        rd_dis;
   logic        rd_flag;
   logic [31:0] en_view;

   // Bundle the command port
   always_comb begin
      cmd.valid = cmd_valid_in;
      cmd.code  = cmd_code_in;
      cmd.wdata = cmd_wdata_in;
   end

   // Command decode
   assign wr_en   = cmd.valid && (cmd.code == CMD_EN_WR);
   assign rd_en   = cmd.valid && (cmd.code == CMD_EN_RD);
   assign wr_dis  = cmd.valid && (cmd.code == CMD_DIS_WR);
   assign rd_dis  = cmd.valid && (cmd.code == CMD_DIS_RD);
   assign wr_flag = cmd.valid && (cmd.code == CMD_FLAG_WR);
   assign rd_flag = cmd.valid && (cmd.code == CMD_FLAG_RD);

   // Write-one clear of status flags
   assign flag_clr = wr_flag ? (cmd.wdata[6:0] & EVT_MASK) : 7'h00;

   // Enable word as both ports present it, reserved bits zero
   assign en_view = {st_r.gate, 24'h00_0000, st_r.en & EVT_MASK};

   // Status flags of the events
   hie_evt_flags #(
      .N          (EVT_W)
   ) u_flags (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .sw_rst_in  (sw_rst_in),
      .set_in     (evt_in),
      .clr_in     (flag_clr),
      .flags_out  (flags)
   );

   // Next state of enables, read answer and request
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;

      // Enable write sets ones and ignores zeros
      if (wr_en) begin
         if (cmd.wdata[GATE_BIT]) begin
            st_nxt.gate = 1'b1;
         end
         st_nxt.en = st_r.en | (cmd.wdata[6:0] & EVT_MASK);
      end

      // Clear port write drops ones, keeps zeros, same bit positions
      if (wr_dis) begin
         if (cmd.wdata[GATE_BIT]) begin
            st_nxt.gate = 1'b0;
         end
         st_nxt.en = st_r.en & ~cmd.wdata[6:0];
      end

      // Read answers; unknown codes are not answered
      if (rd_en || rd_dis) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = en_view;
      end else if (rd_flag) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = {25'h000_0000, flags & EVT_MASK};
      end

      // Request when a flag meets its enable under the gate
      st_nxt.irq = st_r.gate && ((flags & st_r.en & EVT_MASK) != 7'h00);

      // Software reset returns gate, enables and request to their reset values; read data is kept
      if (sw_rst_in) begin
         st_nxt.gate   = 1'b0;
         st_nxt.en     = EN_RESET[6:0];
         st_nxt.irq    = 1'b0;
      end
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_r.gate   <= 1'b0;
         st_r.en     <= EN_RESET[6:0];
         st_r.rdata  <= RD_ZERO;
         st_r.rvalid <= 1'b0;
         st_r.irq    <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign rdata_out       = st_r.rdata;
   assign rdata_valid_out = st_r.rvalid;
   assign irq_out         = st_r.irq;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // Hardware reset leaves everything disabled
   hw_reset_a : assert property (disable iff (1'b0)
      rst_in |=> (!st_r.gate && st_r.en == 7'h00 && !irq_out))
      else $error("reset did not clear enables");

   // Software reset leaves everything disabled
   sw_reset_a : assert property (sw_rst_in
      |=> (!st_r.gate && st_r.en == 7'h00 && !irq_out))
      else $error("software reset did not clear enables");

   // Gate set by a one in bit 31
   gate_set_a : assert property ((wr_en && cmd.wdata[31] && !sw_rst_in)
      |=> st_r.gate)
      else $error("gate not set by enable write");

   // Enable write only adds bits
   en_set_a : assert property ((wr_en && !sw_rst_in)
      |=> st_r.en == ($past(st_r.en) | ($past(cmd_wdata_in[6:0]) & 7'h7D)))
      else $error("enable write result wrong");

   // Zero write to enable changes nothing
   zero_write_a : assert property ((wr_en && cmd.wdata == 32'h0 && !sw_rst_in)
      |=> $stable(st_r.gate) && $stable(st_r.en))
      else $error("zero write changed enables");

   // Clear port clears exactly the ones
   dis_clear_a : assert property ((wr_dis && !sw_rst_in)
      |=> st_r.en == ($past(st_r.en) & ~$past(cmd_wdata_in[6:0])))
      else $error("clear port result wrong");

   // Gate dropped by a one in bit 31
   gate_clear_a : assert property ((wr_dis && cmd.wdata[31])
      |=> !st_r.gate)
      else $error("gate not cleared by clear port");

   // Gate unchanged by a zero in bit 31 of the clear port
   gate_keep_a : assert property ((wr_dis && !cmd.wdata[31] && !sw_rst_in)
      |=> $stable(st_r.gate))
      else $error("gate moved on zero write");

   // Clear port read mirrors the enable word
   read_dis_a : assert property (rd_dis
      |=> rdata_valid_out && rdata_out == $past(en_view))
      else $error("clear port read wrong");

   // Reserved bits of the enable word always read zero on enable and clear port reads
   reserved_a : assert property ((rdata_valid_out && $past(rd_en || rd_dis))
      |-> (rdata_out & 32'h7FFF_FF82) == 32'h0)
      else $error("reserved bits read nonzero");

   // Request follows flags, enables and gate one cycle later
   irq_follow_a : assert property (!sw_rst_in
      |=> irq_out == ($past(st_r.gate) && (($past(flags) & $past(st_r.en)) != 7'h00)))
      else $error("interrupt request mismatch");

   // Main scenarios
   irq_seen_c   : cover property (irq_out);
   gate_drop_c  : cover property (irq_out ##1 (wr_dis && cmd.wdata[31]) ##2 !irq_out);
   dis_read_c   : cover property (wr_en ##1 rd_dis ##1 rdata_valid_out);
   flag_clear_c : cover property (wr_flag && flags != 7'h00);

endmodule

// ---- core/hie_pkg.sv ----
// Constants and carrier types for the host interrupt enable and mask block
// Behaviour
// - Writing 1 to enable bit 31 sets the global interrupt gate; 0 ignored.
// - Enable bits 6 and 5 gate hub change and frame wrap events; 0 ignored.
// - Enable bits 4 and 3 gate fatal fault and resume events; 0 ignored.
// - Enable bits 2 and 0 gate frame begin and schedule overrun; 0 ignored.
// - Each clear port bit maps to the same status and enable bit.
// - Clear port write clears every enable bit written with 1.
// - Clear port write leaves every enable bit written with 0 unchanged.
// - Clear port read returns current enable register contents.
// - Clear port uses read code 05 and write code 85.
// - Writing 1 to clear port bit 31 drops the global gate; 0 ignored.
// - Clear port bits 6,5,4,3,2,0 clear the matching event enables.
// - Hardware or software reset clears gate and all enable bits.
// - Interrupt requested when flag and its enable and the gate are set.
// - Enable write sets ones, ignores zeros; read code 04, write 84.
// - Event flags set by hardware, cleared only by host writing 1; the code also clears them on software reset.
package hie_pkg;

   // Command codes, bit 7 marks a write
   localparam logic [7:0]  CMD_FLAG_RD  = 8'h03;
   localparam logic [7:0]  CMD_FLAG_WR  = 8'h83;
   localparam logic [7:0]  CMD_EN_RD    = 8'h04;
   localparam logic [7:0]  CMD_EN_WR    = 8'h84;
   localparam logic [7:0]  CMD_DIS_RD   = 8'h05;
   localparam logic [7:0]  CMD_DIS_WR   = 8'h85;

   // Field layout
   localparam int          EVT_W        = 7;
   localparam int          GATE_BIT     = 31;
   localparam int          HUB_BIT      = 6;
   localparam int          WRAP_BIT     = 5;
   localparam int          FAULT_BIT    = 4;
   localparam int          RESUME_BIT   = 3;
   localparam int          FRAME_BIT    = 2;
   localparam int          OVERRUN_BIT  = 0;
   localparam logic [6:0]  EVT_MASK     = 7'h7D;
   localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
   localparam logic [31:0] EN_RESET     = 32'h0000_0000;

   // Whole state of the top module
   typedef struct packed {
      logic        gate;
      logic [6:0]  en;
      logic [31:0] rdata;
      logic        rvalid;
      logic        irq;
   } hie_state_t;

   // Whole state of the event flag module
   typedef struct packed {
      logic [6:0]  flags;
   } hie_flag_t;

   // One command from the host side
   typedef struct packed {
      logic        valid;
      logic [7:0]  code;
      logic [31:0] wdata;
   } hie_cmd_t;

endpackage

// ---- core/hie_evt_flags.sv ----
// Sticky event flags that hardware sets and the host clears by writing ones
`timescale 1ns/10ps
module hie_evt_flags
   import hie_pkg::*;
#(
   parameter int N = EVT_W
) (
   input  wire logic         ref_clk_in,  // Controller clock
   input  wire logic         rst_in,      // Sync reset, high
   input  wire logic         sw_rst_in,   // Software reset pulse
   input  wire logic [N-1:0] set_in,      // Event pulses
   input  wire logic [N-1:0] clr_in,      // Host write-one clears
   output logic      [N-1:0] flags_out    // Registered flags
);

   // Refuse widths the layout cannot serve
   if (N != EVT_W) begin : g_bad_width
      $error("flag width must equal event width");
   end

   hie_flag_t st_r;
   hie_flag_t st_nxt;

   // Set wins over clear; hardware never clears a flag itself
   always_comb begin
      st_nxt = st_r;
      st_nxt.flags = (st_r.flags & ~clr_in) | set_in;
      st_nxt.flags = st_nxt.flags & EVT_MASK;
      if (sw_rst_in) begin
         st_nxt.flags = '0;
      end
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flags_out = st_r.flags;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // A set flag stays until host clears it
   flag_hold_a : assert property ((st_r.flags != 0 && clr_in == 0 && !sw_rst_in)
      |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
      else $error("event flag dropped without a clear");

   // Event in the clear cycle still lands
   set_wins_a : assert property ((set_in[0] && clr_in[0] && !sw_rst_in)
      |=> st_r.flags[0])
      else $error("event lost against clear");

endmodule

// ---- tb/hie_host_model.sv ----
// Host processor model that issues commands on the controller port
`timescale 1ns/10ps
module hie_host_model
   import hie_pkg::*;
(
   input  wire logic        ref_clk_in,    // Controller clock
   output logic             cmd_valid_out, // Command strobe
   output logic [7:0]       cmd_code_out,  // Command code
   output logic [31:0]      cmd_wdata_out  // Write data
);
   // Quiet bus at time zero
   initial begin
      cmd_valid_out = 1'b0;
      cmd_code_out  = 8'h00;
      cmd_wdata_out = 32'h0000_0000;
   end
   // Present one command for one edge; calls in a row fill every cycle
   task automatic send(input logic [7:0] code, input logic [31:0] data);
      @(negedge ref_clk_in);
      cmd_valid_out = 1'b1;
      cmd_code_out  = code;
      cmd_wdata_out = data;
      @(posedge ref_clk_in);
   endtask
   // Drop the strobe; code and data flip so stale values never look valid
   task automatic idle();
      @(negedge ref_clk_in);
      cmd_valid_out = 1'b0;
      cmd_code_out  = ~cmd_code_out;
      cmd_wdata_out = ~cmd_wdata_out;
   endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the interrupt enable and mask block
`timescale 1ns/10ps
module tb_top;
   import hie_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic        sw_rst_in  = 1'b0;
   logic [6:0]  evt_in     = 7'h00;
   logic        cmd_valid;
   logic [7:0]  cmd_code;
   logic [31:0] cmd_wdata;
   logic [31:0] rdata_out;
   logic        rdata_valid_out;
   logic        irq_out;
   logic [31:0] exp_en = 32'h0000_0000;
   logic [31:0] d;
   logic [31:0] exp_q[$];
   int          err_total = 0;
   int          n_tests   = 0;
   int          cycles    = 0;
   int          seed      = 32'h42064419;
   int          bits[6]   = '{6, 5, 4, 3, 2, 0};

   always #20 ref_clk_in = ~ref_clk_in;

   hie_host_model i_hie_host_model (.ref_clk_in(ref_clk_in), .cmd_valid_out(cmd_valid),
      .cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata));
   hie_top i_hie_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sw_rst_in(sw_rst_in),
      .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata), .evt_in(evt_in),
      .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out), .irq_out(irq_out));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Writes update the expected enable word, reserved bits dropped
   task automatic wr(input logic [7:0] code, input logic [31:0] data);
      if (code == CMD_EN_WR) exp_en = exp_en | (data & 32'h8000_007D);
      if (code == CMD_DIS_WR) exp_en = exp_en & ~data;
      i_hie_host_model.send(code, data);
   endtask

   task automatic rd(input logic [7:0] code, input logic [31:0] exp);
      exp_q.push_back(exp);
      i_hie_host_model.send(code, 32'h0000_0000);
   endtask

   task automatic pulse(input logic [6:0] b);
      @(negedge ref_clk_in);
      evt_in = b;
      @(negedge ref_clk_in);
      evt_in = 7'h00;
      repeat (2) @(negedge ref_clk_in);
   endtask

   task automatic wr_wait(input logic [7:0] code, input logic [31:0] data);
      wr(code, data);
      i_hie_host_model.idle();
      repeat (2) @(negedge ref_clk_in);
   endtask

   // Every read answer is matched with the oldest expectation
   always @(negedge ref_clk_in) begin
      if (rdata_valid_out === 1'b1) begin
         if (exp_q.size() == 0) check("unasked_answer", rdata_valid_out, 32'h0);
         else check("read_data", rdata_out, exp_q.pop_front());
      end
   end

   // Hang guard
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         $display("timeout reached");
         stop_test();
      end
   end

   initial begin
      repeat (6) @(negedge ref_clk_in);
      rst_in = 1'b0;
      rd(CMD_EN_RD, 32'h0000_0000);
      rd(CMD_DIS_RD, 32'h0000_0000);
      rd(CMD_FLAG_RD, 32'h0000_0000);
      i_hie_host_model.send(8'h06, 32'h0000_0000);
      wr(CMD_EN_WR, 32'h0000_0000);
      rd(CMD_EN_RD, 32'h0000_0000);
      i_hie_host_model.idle();
      $display("test reset done");
      // Random set and clear writes, each read back on the next cycle
      repeat (24) begin
         d = $random(seed);
         wr(d[0] ? CMD_EN_WR : CMD_DIS_WR, d);
         rd(d[1] ? CMD_EN_RD : CMD_DIS_RD, exp_en);
      end
      i_hie_host_model.idle();
      $display("test random access done");
      // Each event raises the request, its clear port bit removes it
      foreach (bits[k]) begin
         wr_wait(CMD_EN_WR, 32'h8000_0000 | (32'h1 << bits[k]));
         pulse(7'h01 << bits[k]);
         check("irq_raised", irq_out, 32'h1);
         wr_wait(CMD_DIS_WR, 32'h1 << bits[k]);
         check("irq_bit_cleared", irq_out, 32'h0);
         wr_wait(CMD_FLAG_WR, 32'h1 << bits[k]);
      end
      $display("test event gating done");
      // Global gate off holds back the request for a new flag; gate on raises it with the flag held
      wr_wait(CMD_EN_WR, 32'h0000_0004);
      wr_wait(CMD_DIS_WR, 32'h8000_0000);
      pulse(7'h04);
      check("irq_gate_off", irq_out, 32'h0);
      wr_wait(CMD_EN_WR, 32'h8000_0000);
      check("irq_gate_on", irq_out, 32'h1);
      $display("test global gate done");
      // Event in the cycle of its clear keeps the flag; gate drop removes the request
      fork
         i_hie_host_model.send(CMD_FLAG_WR, 32'h0000_0001);
         begin
            @(negedge ref_clk_in);
            evt_in = 7'h01;
         end
      join
      i_hie_host_model.idle();
      evt_in = 7'h00;
      rd(CMD_FLAG_RD, 32'h0000_0005);
      wr_wait(CMD_DIS_WR, 32'h8000_0000);
      check("irq_gate_drop", irq_out, 32'h0);
      wr_wait(CMD_EN_WR, 32'h8000_0000);
      $display("test set wins done");
      // Software reset clears gate, enables and request
      @(negedge ref_clk_in);
      sw_rst_in = 1'b1;
      @(negedge ref_clk_in);
      sw_rst_in = 1'b0;
      exp_en = 32'h0000_0000;
      @(negedge ref_clk_in);
      check("irq_after_sw_reset", irq_out, 32'h0);
      rd(CMD_DIS_RD, 32'h0000_0000);
      rd(CMD_FLAG_RD, 32'h0000_0000);
      i_hie_host_model.idle();
      repeat (3) @(negedge ref_clk_in);
      check("pending_reads", exp_q.size(), 32'h0);
      $display("test software reset done");
      stop_test();
   end
endmodule
